// ===== link_pkg.sv
// Shared constants and carrier types for the host serial command link
package link_pkg;
  // Message layout
  localparam logic [7:0] GRP_SYSTEM = 8'h01;
  localparam logic [7:0] OP_SET_TIME = 8'h42;
  localparam logic [7:0] OP_GET_TIME = 8'h43;
  localparam logic [7:0] ACK_LEN = 8'h02;
  localparam logic [7:0] ACK_OK = 8'h01;
  localparam logic [7:0] RSP_ERROR = 8'h02;
  localparam logic [7:0] SET_TIME_LEN = 8'h0b;
  localparam logic [7:0] GET_TIME_LEN = 8'h03;
  localparam logic [7:0] TIME_RSP_LEN = 8'h0a;
  localparam logic [7:0] ERR_BAD_CMD = 8'h01;
  localparam int MAX_MSG = 16;
  // Timing
  localparam int CLK_HZ = 100_000_000;
  localparam int INIT_NS = 1000;
  localparam int INIT_CYC = INIT_NS / (1_000_000_000 / CLK_HZ);
  localparam int PULSE_NS = 100;
  localparam int PULSE_CYC = PULSE_NS / (1_000_000_000 / CLK_HZ);
  localparam int FLASH_CYC_DEF = 25_000_000;
  // Byte stream beat
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_beat_t;
  // Clock and calendar fields in message order
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] date;
    logic [7:0] wday;
    logic [7:0] month;
    logic [15:0] year;
  } time_t;
endpackage

// ===== rsp_queue.sv
// Response byte queue kept in arrival order
`timescale 1ns/1ps
`default_nettype none
module rsp_queue #(
  parameter int DEPTH = 64
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Fill side
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic full,
  // Drain side
  input wire logic rd_en,
  output logic [7:0] rd_data,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);
  logic [7:0] mem [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;

  assign empty = (wp_q == rp_q);
  assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign rd_data = mem[rp_q[AW-1:0]];

  // Storage has no reset; pointers alone decide what is held
  always_ff @(posedge clk)
  begin
    if (wr_en && !full)
      mem[wp_q[AW-1:0]] <= wr_data;
  end

  // Pointers clear on reset so queued responses are dropped
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wp_q <= '0;
      rp_q <= '0;
    end
    else
    begin
      if (wr_en && !full)
        wp_q <= wp_q + (AW+1)'(1);
      if (rd_en && !empty)
        rp_q <= rp_q + (AW+1)'(1);
    end
  end
endmodule // rsp_queue
`default_nettype wire

// ===== host_serial_command_link.sv
// Command interpreter and handshake logic for the host serial link
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// (R01) Every received command produces exactly one response.
// (R02) Unsolicited responses may be queued at any time; the code holds them off while a reply is copied in or the queue is full.
// (R03) Next command accepted only after current one's response is generated.
// (R04) Host waits for response before sending another command.
// (R05) Host holds ready line high idle, low when ready to receive.
// (R06) Queued bytes are sent only while host ready line is low.
// (R07) Pending output high while any response waits for the host.
// (R08) After initialization the pending output pulses high once.
// (R09) First byte of every message is its total length.
// (R10) Successful set-time replies 02 01.
// (R11) Time query returns ten bytes: length, 43, time fields.
// (R12) Red error indicator set on receive error, cleared by valid bytes.
// (R13) Button held at power-up enters programming wait, both LEDs flash.
// (R14) After programming, stay connected or reset into run mode.
// (R15) Host resets device and waits for readiness before commanding.
// (R16) Failed command answered with second byte 02.
// (R17) Short command leaves reception waiting indefinitely.
// (R18) Reset drops partial command, queued responses, length counter.
// (R19) Multiple responses queue in order; pending stays high until empty.
module host_serial_command_link
  import link_pkg::*;
#(
  parameter int QDEPTH = 64,
  parameter int FLASH_CYC = FLASH_CYC_DEF
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Received bytes from the serial receiver
  input wire link_pkg::byte_beat_t RX_BYTE,
  input wire logic RX_ERROR,
  // Transmit bytes to the serial transmitter
  output link_pkg::byte_beat_t TX_BYTE,
  input wire logic TX_READY,
  // Handshake lines
  input wire logic HOST_FLOW_CONTROL_INPUT_N,
  output logic RESPONSE_PENDING_OUTPUT,
  // Unsolicited response bytes from the radio side
  input wire link_pkg::byte_beat_t UNSOL_BYTE,
  output logic UNSOL_READY,
  // Board controls
  input wire logic BUTTON,
  input wire logic PROG_DONE,
  input wire logic PROG_STAY,
  output logic PROG_MODE,
  output logic LED_RED,
  output logic LED_GREEN,
  // Calendar
  input wire link_pkg::time_t TIME_NOW,
  output link_pkg::time_t TIME_SET,
  output logic TIME_SET_STB
);
  typedef enum {S_INIT, S_PULSE, S_PROG, S_IDLE, S_RECV, S_EXEC, S_REPLY} state_t;
  state_t state_q;
  logic [7:0] buf_q [MAX_MSG];
  logic [7:0] want_q;
  logic [7:0] got_q;
  logic [31:0] cnt_q;
  logic [7:0] rsp_q [10];
  logic [3:0] rlen_q;
  logic [3:0] ridx_q;
  logic q_full;
  logic q_empty;
  logic q_wr;
  logic [7:0] q_wdata;
  logic [7:0] q_rdata;
  logic q_rd;
  logic err_q;
  logic flash_q;
  logic take;
  logic rx_ok;
  logic [31:0] fcnt_q;

  // Builds a reply byte list entry from the time fields
  function automatic logic [7:0] time_byte(input time_t t, input int i);
    logic [7:0] v;
    v = 8'h00;
    case (i)
      2: v = t.sec;
      3: v = t.min;
      4: v = t.hour;
      5: v = t.date;
      6: v = t.wday;
      7: v = t.month;
      8: v = t.year[7:0];
      9: v = t.year[15:8];
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  assign rx_ok = RX_BYTE.valid && !RX_ERROR;
  // Reply bytes have priority; unsolicited bytes fill the queue otherwise
  assign q_wr = (state_q == S_REPLY) ? !q_full : (UNSOL_BYTE.valid && !q_full); // R02
  assign q_wdata = (state_q == S_REPLY) ? rsp_q[ridx_q] : UNSOL_BYTE.data;
  // Unsolicited bytes must arrive as whole messages to keep order intact;
  // the producer is held off while a reply is being copied in
  assign UNSOL_READY = (state_q != S_REPLY) && !q_full;
  // Reply copy advances only on a cycle in which the queue takes the byte
  assign take = (state_q == S_REPLY) && !q_full;

  rsp_queue #(
    .DEPTH(QDEPTH)
  ) u_q (
    .clk(CLK),
    .nrst(NRST),
    .wr_en(q_wr),
    .wr_data(q_wdata),
    .full(q_full),
    .rd_en(q_rd),
    .rd_data(q_rdata),
    .empty(q_empty)
  );

  // Drain only while the host signals it is waiting in its receive
  assign q_rd = !q_empty && !HOST_FLOW_CONTROL_INPUT_N && TX_READY; // R06 R19

  // Transmit beat registered so the data output comes from a flop
  // Data follows the read pointer even when idle; only valid marks a byte
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      TX_BYTE <= '0;
    else
    begin
      TX_BYTE.valid <= q_rd; // R06
      TX_BYTE.data <= q_rdata;
    end
  end

  // Pending output: readiness pulse, then queue occupancy
  // It falls one cycle after the last byte leaves, so the host sees it drop
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      RESPONSE_PENDING_OUTPUT <= 1'b0;
    else if (state_q == S_PULSE)
      RESPONSE_PENDING_OUTPUT <= 1'b1; // R08
    else if (state_q == S_INIT || state_q == S_PROG)
      RESPONSE_PENDING_OUTPUT <= 1'b0;
    else
      RESPONSE_PENDING_OUTPUT <= !q_empty || (state_q == S_REPLY); // R07 R19
  end

  // Main sequencer
  // One command at a time: bytes that arrive in EXEC or REPLY are dropped
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      state_q <= S_INIT; // R18
      want_q <= 8'h00;
      got_q <= 8'h00;
      cnt_q <= '0;
      rlen_q <= 4'h0;
      ridx_q <= 4'h0;
      TIME_SET_STB <= 1'b0;
      TIME_SET <= '0;
      PROG_MODE <= 1'b0;
    end
    else
    begin
      TIME_SET_STB <= 1'b0;
      case (state_q)
        S_INIT:
        begin
          cnt_q <= cnt_q + 32'h1;
          if (cnt_q == 32'(INIT_CYC - 1))
          begin
            cnt_q <= '0;
            // Button sampled once initialization has settled
            if (BUTTON)
            begin
              state_q <= S_PROG; // R13
              PROG_MODE <= 1'b1;
            end
            else
              state_q <= S_PULSE;
          end
        end
        S_PULSE:
        begin
          cnt_q <= cnt_q + 32'h1;
          if (cnt_q == 32'(PULSE_CYC - 1))
          begin
            cnt_q <= '0;
            state_q <= S_IDLE; // R08 R15
          end
        end
        S_PROG:
        begin
          // Stay option keeps the link; otherwise restart into run mode
          // The button is not looked at again until the next pass through init
          if (PROG_DONE && !PROG_STAY)
          begin
            PROG_MODE <= 1'b0; // R14
            state_q <= S_INIT;
          end
        end
        S_IDLE:
        begin
          if (rx_ok)
          begin
            // A length of zero or one cannot hold a command: straight to the error reply
            want_q <= RX_BYTE.data; // R09
            buf_q[0] <= RX_BYTE.data;
            got_q <= 8'h01;
            state_q <= (RX_BYTE.data <= 8'h01) ? S_EXEC : S_RECV;
          end
        end
        S_RECV:
        begin
          // No timeout: a short command waits here for ever
          if (rx_ok)
          begin
            if (got_q < 8'(MAX_MSG))
              buf_q[got_q[3:0]] <= RX_BYTE.data;
            got_q <= got_q + 8'h01;
            if (got_q + 8'h01 == want_q)
              state_q <= S_EXEC; // R17 R03
          end
        end
        S_EXEC:
        begin
          ridx_q <= 4'h0;
          if (want_q == SET_TIME_LEN && buf_q[1] == GRP_SYSTEM && buf_q[2] == OP_SET_TIME)
          begin
            TIME_SET <= {buf_q[3], buf_q[4], buf_q[5], buf_q[6], buf_q[7], buf_q[8],
                         buf_q[10], buf_q[9]};
            TIME_SET_STB <= 1'b1;
            rsp_q[0] <= ACK_LEN; // R10
            rsp_q[1] <= ACK_OK;
            rlen_q <= 4'h2;
          end
          else if (want_q == GET_TIME_LEN && buf_q[1] == GRP_SYSTEM && buf_q[2] == OP_GET_TIME)
          begin
            rsp_q[0] <= TIME_RSP_LEN; // R11
            rsp_q[1] <= OP_GET_TIME;
            for (int i = 2; i < 10; i++)
              rsp_q[i] <= time_byte(TIME_NOW, i);
            rlen_q <= 4'ha;
          end
          else
          begin
            // Short, unknown or malformed commands all get the error report
            rsp_q[0] <= 8'h03; // R16
            rsp_q[1] <= RSP_ERROR;
            rsp_q[2] <= ERR_BAD_CMD;
            rlen_q <= 4'h3;
          end
          state_q <= S_REPLY; // R01
        end
        S_REPLY:
        begin
          if (take)
          begin
            ridx_q <= ridx_q + 4'h1;
            if (ridx_q + 4'h1 == rlen_q)
              state_q <= S_IDLE; // R03
          end
        end
        default: state_q <= S_INIT;
      endcase
    end
  end

  // Error indicator: set by a bad byte, dropped by the next good one
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      err_q <= 1'b0;
    else if (RX_ERROR)
      err_q <= 1'b1; // R12
    else if (RX_BYTE.valid)
      err_q <= 1'b0; // R12
  end

  // Flash timer used while waiting for the programming link; it runs freely
  // because only the programming wait looks at it, and both lamps share it
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      fcnt_q <= '0;
      flash_q <= 1'b0;
    end
    else if (fcnt_q == 32'(FLASH_CYC - 1))
    begin
      fcnt_q <= '0;
      flash_q <= !flash_q;
    end
    else
      fcnt_q <= fcnt_q + 32'h1;
  end

  // Both indicators flash together in programming wait
  assign LED_RED = (state_q == S_PROG) ? flash_q : err_q; // R13 R12
  assign LED_GREEN = (state_q == S_PROG) && flash_q; // R13
endmodule // host_serial_command_link
`default_nettype wire

// ===== link_props.sv
// Checker on the ports of the host serial command link
`timescale 1ns/1ps
`default_nettype none
module link_props
  import link_pkg::*;
(
  // Watched ports
  input wire logic CLK,
  input wire logic NRST,
  input wire link_pkg::byte_beat_t RX_BYTE,
  input wire logic RX_ERROR,
  input wire link_pkg::byte_beat_t TX_BYTE,
  input wire logic TX_READY,
  input wire logic HOST_FLOW_CONTROL_INPUT_N,
  input wire logic RESPONSE_PENDING_OUTPUT,
  input wire logic BUTTON,
  input wire logic PROG_MODE,
  input wire logic LED_RED,
  input wire logic LED_GREEN,
  input wire logic TIME_SET_STB
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // Transmit is a registered beat, so its cause sits one cycle back
  a_tx_flow_low: assert property (TX_BYTE.valid |-> !$past(HOST_FLOW_CONTROL_INPUT_N))
    else $error("byte sent while host not waiting");
  a_tx_ready_ok: assert property (TX_BYTE.valid |-> $past(TX_READY))
    else $error("byte sent while transmitter busy");
  a_pend_covers_tx: assert property (TX_BYTE.valid |-> $past(RESPONSE_PENDING_OUTPUT))
    else $error("byte sent without pending flag");
  a_init_quiet: assert property ($rose(NRST) |-> !RESPONSE_PENDING_OUTPUT [*8])
    else $error("pending high during init");
  a_init_pulse: assert property ($rose(NRST) && !BUTTON |-> ##[90:120] RESPONSE_PENDING_OUTPUT)
    else $error("no ready pulse after init");
  a_prog_flash: assert property (PROG_MODE |-> LED_RED == LED_GREEN)
    else $error("indicators not in unison");
  a_err_red: assert property (RX_ERROR && !PROG_MODE |-> ##[1:2] LED_RED)
    else $error("red not lit on receive error");
  a_red_clear: assert property (RX_BYTE.valid && !RX_ERROR && !PROG_MODE |-> ##[1:2] !LED_RED)
    else $error("red not cleared by good byte");
  a_set_reply: assert property (TIME_SET_STB |-> ##[0:8] RESPONSE_PENDING_OUTPUT)
    else $error("no reply after clock set");
endmodule // link_props
bind host_serial_command_link link_props link_props_inst (.CLK, .NRST, .RX_BYTE, .RX_ERROR,
  .TX_BYTE, .TX_READY, .HOST_FLOW_CONTROL_INPUT_N, .RESPONSE_PENDING_OUTPUT, .BUTTON,
  .PROG_MODE, .LED_RED, .LED_GREEN, .TIME_SET_STB);
`default_nettype wire

// ===== host_model.sv
// Host side model: flow line, transmitter pacing and reply collector
`timescale 1ns/1ps
`default_nettype none
module host_model
  import link_pkg::*;
(
  // Clock
  input wire logic clk,
  // Link side
  input wire link_pkg::byte_beat_t tx_byte,
  input wire logic pending,
  output logic flow_n,
  output logic tx_ready,
  // Bench control
  input wire logic collect,
  input wire logic slow
);
  logic [7:0] got[$];
  logic ph_q = 1'b0;
  // Line stays high when idle, low only while a reply is wanted and waiting
  always @(posedge clk)
  begin
    flow_n <= !(collect && pending);
    ph_q <= !ph_q;
    if (tx_byte.valid)
      got.push_back(tx_byte.data);
  end
  // Slow mode lets the transmitter accept every other cycle
  assign tx_ready = slow ? ph_q : 1'b1;
endmodule // host_model
`default_nettype wire

// ===== host_serial_command_link_bench.sv
// Self-checking bench for the host serial command link
`timescale 1ns/1ps
`default_nettype none
module host_serial_command_link_bench;
  import link_pkg::*;
  typedef logic [7:0] msg_t[$];
  logic clk, nrst, rx_err, button, pdone, pstay, collect, slow;
  logic flow_n, tx_ready, pend, uready, pmode, red, green, tstb;
  byte_beat_t rx, un, tx;
  time_t tnow, tset;
  int num_errors, checks_done;
  msg_t tq;
  host_serial_command_link #(.FLASH_CYC(4)) host_serial_command_link_inst (.CLK(clk),
    .NRST(nrst), .RX_BYTE(rx), .RX_ERROR(rx_err), .TX_BYTE(tx), .TX_READY(tx_ready),
    .HOST_FLOW_CONTROL_INPUT_N(flow_n), .RESPONSE_PENDING_OUTPUT(pend), .UNSOL_BYTE(un),
    .UNSOL_READY(uready), .BUTTON(button), .PROG_DONE(pdone), .PROG_STAY(pstay),
    .PROG_MODE(pmode), .LED_RED(red), .LED_GREEN(green), .TIME_NOW(tnow),
    .TIME_SET(tset), .TIME_SET_STB(tstb));
  host_model host_model_inst (.clk(clk), .tx_byte(tx), .pending(pend), .flow_n(flow_n),
    .tx_ready(tx_ready), .collect(collect), .slow(slow));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic do_reset(input logic b);
    button <= b;
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
  endtask
  // Ready pulse width, then commands may start
  task automatic t_init;
    int n;
    n = 0;
    while (pend !== 1'b1 && n < 300)
      @(negedge clk) n++;
    n = 0;
    while (pend === 1'b1 && n < 50)
      @(negedge clk) n++;
    chk(n, PULSE_CYC);
  endtask
  // Length byte first, one byte a cycle
  task automatic send(input msg_t m);
    foreach (m[i])
    begin
      @(posedge clk);
      rx <= '{1'b1, m[i]};
    end
    @(posedge clk);
    rx <= '0;
  endtask
  // Collect a whole reply and compare it byte by byte
  task automatic rsp(input msg_t e);
    int n;
    n = 0;
    @(posedge clk);
    collect <= 1'b1;
    while (host_model_inst.got.size() < e.size() && n < 600)
      @(negedge clk) n++;
    @(posedge clk);
    collect <= 1'b0;
    chk(host_model_inst.got.size(), e.size());
    foreach (e[i])
      chk(host_model_inst.got[i], e[i]);
    host_model_inst.got.delete();
  endtask
  task automatic t_set;
    int n;
    n = 0;
    send('{8'h0b, 8'h01, 8'h42, 8'h00, 8'h1e, 8'h16, 8'h14, 8'h05, 8'h05, 8'hd5, 8'h07});
    while (tstb !== 1'b1 && n < 30)
      @(negedge clk) n++;
    chk(tset, {8'h00, 8'h1e, 8'h16, 8'h14, 8'h05, 8'h05, 16'h07d5});
    chk(uready, 1'b0);
    rsp('{8'h02, 8'h01});
  endtask
  // Reply held back while host is busy, then unsolicited bytes follow it in order
  task automatic t_queue;
    send('{8'h03, 8'h01, 8'h43});
    repeat (40) @(negedge clk);
    chk(pend, 1'b1);
    chk(host_model_inst.got.size(), 0);
    chk(uready, 1'b1);
    @(posedge clk);
    un <= '{1'b1, 8'h02};
    @(posedge clk);
    un <= '{1'b1, 8'h77};
    @(posedge clk);
    un <= '0;
    rsp({tq, 8'h02, 8'h77});
    repeat (10) @(negedge clk);
    chk(pend, 1'b0);
  endtask
  task automatic t_serr;
    @(posedge clk);
    rx_err <= 1'b1;
    @(posedge clk);
    rx_err <= 1'b0;
    repeat (3) @(negedge clk);
    chk(red, 1'b1);
    send('{8'h03, 8'h04, 8'h1b});
    rsp('{8'h03, 8'h02, 8'h01});
    chk(red, 1'b0);
  endtask
  // Short command hangs; reset drops it and starts clean
  task automatic t_short;
    send('{8'h03, 8'h01});
    repeat (60) @(negedge clk);
    chk(pend, 1'b0);
    do_reset(1'b0);
    t_init();
    send('{8'h03, 8'h01, 8'h43});
    rsp(tq);
  endtask
  // Slow transmitter: the reply still arrives whole and in order
  task automatic t_slow;
    @(posedge clk);
    slow <= 1'b1;
    send('{8'h03, 8'h01, 8'h43});
    rsp(tq);
    @(posedge clk);
    slow <= 1'b0;
  endtask
  // Button held through reset: programming wait, lamps in unison, both exit options
  task automatic t_prog;
    int n;
    n = 0;
    do_reset(1'b1);
    repeat (150) @(negedge clk);
    chk(pmode, 1'b1);
    // Flash divider of 4 gives four lit cycles in any eight
    repeat (8)
    begin
      @(negedge clk);
      if (red === 1'b1 && green === 1'b1)
        n++;
      chk(red, green);
    end
    chk(n, 4);
    @(posedge clk);
    button <= 1'b0;
    pstay <= 1'b1;
    pdone <= 1'b1;
    @(posedge clk);
    pdone <= 1'b0;
    repeat (4) @(negedge clk);
    chk(pmode, 1'b1);
    @(posedge clk);
    pstay <= 1'b0;
    pdone <= 1'b1;
    @(posedge clk);
    pdone <= 1'b0;
    t_init();
    chk(pmode, 1'b0);
  endtask
  initial
  begin
    nrst = 1'b0;
    rx = '0;
    un = '0;
    rx_err = 1'b0;
    button = 1'b0;
    pdone = 1'b0;
    pstay = 1'b0;
    collect = 1'b0;
    slow = 1'b0;
    tnow = '{8'h11, 8'h22, 8'h09, 8'h03, 8'h02, 8'h07, 16'h07d5};
    tq = '{8'h0a, 8'h43, 8'h11, 8'h22, 8'h09, 8'h03, 8'h02, 8'h07, 8'hd5, 8'h07};
    do_reset(1'b0);
    t_init();
    t_set();
    t_slow();
    t_queue();
    t_serr();
    t_short();
    t_prog();
    end_sim();
  end
  // Whole run is under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_sim();
  end
endmodule // host_serial_command_link_bench
`default_nettype wire
